// ==== shared/ppr_pkg.sv ====
// Purpose: constants for the process PID regulator
// Assumes: percentages in 0.01 % steps, 100.00 % = 10000
// Notes: register map, reset values, tick timing and state codes
// Overview of operation
// - Proportional gain 100.0 on a 100 % deviation gives maximum frequency.
// - Integral reaches maximum frequency after integral time at 100 % deviation.
// - Derivative on feedback: 100 % change within differential time gives max.
// - Negative output magnitude is clamped to reverse cut-off, default 2.00 Hz.
// - Output holds while deviation is below deviation limit; zero disables.
// - Derivative term is clamped to differential limit, default 0.10 %.
// - Setting ramps linearly; full span takes change time; zero is immediate.
// - Feedback and output each have their own low-pass filter.
// - Gain switchover mode: none, by input, or automatic; default none.
// - Input-driven mode: group 1 when select input low, group 2 high.
// - Automatic mode: group 1 below threshold 1, group 2 above 2, interpolate.
// - At start-up output is forced to initial value for hold time.
// - New output every 2 ms, step limited forward and reverse, default 1 %.
// - Integral property: units digit separation, tens digit stop at limit; the code uses control bits 4 and 5 instead.
// - With separation on, integral pause input freezes the integrator.
// - With stop-at-limit on, integrator freezes while output is at limit.
// - Feedback below detection level longer than detection time raises fault.
// - Stop-operation option keeps regulating while stopped; default halts.
// - Forward action: low feedback raises output; reverse action lowers it.
// - Setting and feedback are relative values within 0 to 100 %.
package ppr_pkg;
  localparam int NREG = 16;
  localparam int AW = 8;
  // Register indices; byte address is index times four
  localparam logic [3:0] R_GAIN1 = 4'h0;
  localparam logic [3:0] R_TD = 4'h1;
  localparam logic [3:0] R_GAIN2 = 4'h2;
  localparam logic [3:0] R_CTRL = 4'h3;
  localparam logic [3:0] R_THR = 4'h4;
  localparam logic [3:0] R_LIMIT = 4'h5;
  localparam logic [3:0] R_FILT = 4'h6;
  localparam logic [3:0] R_RAMP = 4'h7;
  localparam logic [3:0] R_HOLD = 4'h8;
  localparam logic [3:0] R_STEP = 4'h9;
  localparam logic [3:0] R_LOSS = 4'hA;
  localparam logic [3:0] R_MAXF = 4'hB;
  localparam logic [3:0] R_STAT = 4'hC;
  localparam logic [3:0] R_OUT = 4'hD;
  // Control field positions
  localparam int C_DIR = 0;
  localparam int C_SW = 1;
  localparam int C_ISEP = 4;
  localparam int C_ISTOP = 5;
  localparam int C_STOPOP = 6;
  // Reset values
  localparam logic [31:0] RST_VAL [NREG] = '{
    32'h00C8_00C8, 32'h0000_0000, 32'h00C8_00C8, 32'h0000_0000,
    32'h1F40_07D0, 32'h000A_0000, 32'h0000_0000, 32'h0000_0000,
    32'h00C8_0000, 32'h0064_0064, 32'h0000_0000, 32'h0000_1388,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  // Scaling
  localparam int FULL = 10000;
  localparam int KP_UNIT = 1000;
  localparam int TI_DIV = 5;
  localparam int TD_DIV = 2;
  localparam int RAMP_NUM = 2000;
  localparam int LOSS_MUL = 50;
  // Timing
  localparam int CLK_NS = 8;
  localparam int TICK_MS = 2;
  localparam int TICK_CYC = TICK_MS * 1000000 / CLK_NS;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN = 2'b11
  } ppr_state_t;
  typedef enum logic [1:0] {
    SW_NONE = 2'b00,
    SW_INPUT = 2'b01,
    SW_AUTO = 2'b10
  } ppr_sw_t;
endpackage : ppr_pkg

// ==== rtl/ppr_regulator.sv ====
// Purpose: process PID regulator with APB register access
// Assumes: inputs synchronous to REF_CLK, 125 MHz
// Notes: arithmetic runs once per 2 ms tick, except the hold output, set every cycle
`timescale 1ns/1ps
`default_nettype none
module ppr_regulator
  import ppr_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [15:0] SETTING,
  input wire logic [15:0] FEEDBACK,
  input wire logic RUN,
  input wire logic GAIN_SEL_IN,
  input wire logic INT_PAUSE_IN,
  output logic signed [31:0] FREQ_REF,
  output logic FEEDBACK_LOSS_FAULT
);
  typedef logic signed [31:0] ppr_s32_t;

  function automatic ppr_s32_t clamp(input ppr_s32_t v, lo, hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  // First-order low-pass on the tick; zero time passes through
  function automatic ppr_s32_t lpf(input ppr_s32_t y, x,
                                   input logic [15:0] tau);
    ppr_s32_t dn;
    dn = $signed(32'(tau)) * TI_DIV + 1;
    lpf = (tau == 16'h0000) ? x : y + (x - y) / dn;
  endfunction : lpf

  // Gain blend between the two thresholds
  function automatic ppr_s32_t mix(input logic [15:0] a, b,
                                   input ppr_s32_t ae,
                                   input logic [15:0] t1, t2);
    ppr_s32_t sa;
    ppr_s32_t sb;
    sa = $signed(32'(a));
    sb = $signed(32'(b));
    if (ae <= $signed(32'(t1)))
      mix = sa;
    else if (ae >= $signed(32'(t2)) || t2 <= t1)
      mix = sb;
    else
      mix = sa + (sb - sa) * (ae - $signed(32'(t1)))
            / $signed(32'(t2 - t1));
  endfunction : mix

  // Register file and APB slave
  logic [31:0] cfg_q [NREG];
  logic [31:0] cfg_d [NREG];
  logic [31:0] prdata_q, prdata_d;
  logic [3:0] idx;
  logic mapped, acc_ph, fault_clr;
  ppr_state_t st_q, st_d;
  logic fault_q, fault_d, grp2_q, grp2_d;
  ppr_s32_t hz_q, hz_d;

  assign idx = PADDR[5:2];
  assign mapped = (PADDR[1:0] == 2'h0) && (PADDR[7:6] == 2'h0)
                  && (idx <= R_OUT);
  assign acc_ph = PSEL && PENABLE;
  assign PREADY = acc_ph;
  assign PSLVERR = acc_ph && !mapped;
  assign PRDATA = prdata_q;
  assign fault_clr = acc_ph && PWRITE && mapped && (idx == R_STAT)
                     && PWDATA[0];

  // Config writes at the access edge, read data latched at setup
  always_comb
  begin
    cfg_d = cfg_q;
    prdata_d = prdata_q;
    if (acc_ph && PWRITE && mapped && idx < R_STAT)
      cfg_d[idx] = PWDATA;
    if (PSEL && !PENABLE)
    begin
      if (!mapped)
        prdata_d = 32'h0000_0000;
      else if (idx == R_STAT)
        prdata_d = {28'h000_0000, grp2_q, st_q, fault_q};
      else if (idx == R_OUT)
        prdata_d = hz_q;
      else
        prdata_d = cfg_q[idx];
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      for (int i = 0; i < NREG; i++)
        cfg_q[i] <= RST_VAL[i];
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      cfg_q <= cfg_d;
      prdata_q <= prdata_d;
    end
  end

  // Field views
  logic [15:0] kp1, ti1, td1, kp2, ti2, td2, th1, th2, devlim, dlim;
  logic [15:0] fbtau, otau, ramp, initv, hold, cutoff, stepf, stepr;
  logic [15:0] losslvl, losstime, maxf;
  logic dir, isep, istop, stopop;
  ppr_sw_t swm;
  assign {ti1, kp1} = cfg_q[R_GAIN1];
  assign {ti2, kp2} = cfg_q[R_GAIN2];
  assign {td2, td1} = cfg_q[R_TD];
  assign {th2, th1} = cfg_q[R_THR];
  assign {dlim, devlim} = cfg_q[R_LIMIT];
  assign {otau, fbtau} = cfg_q[R_FILT];
  assign {initv, ramp} = cfg_q[R_RAMP];
  assign {cutoff, hold} = cfg_q[R_HOLD];
  assign {stepr, stepf} = cfg_q[R_STEP];
  assign {losstime, losslvl} = cfg_q[R_LOSS];
  assign maxf = cfg_q[R_MAXF][15:0];
  assign dir = cfg_q[R_CTRL][C_DIR];
  assign swm = ppr_sw_t'(cfg_q[R_CTRL][C_SW+:2]);
  assign isep = cfg_q[R_CTRL][C_ISEP];
  assign istop = cfg_q[R_CTRL][C_ISTOP];
  assign stopop = cfg_q[R_CTRL][C_STOPOP];

  // 2 ms tick divider
  logic [17:0] tcnt_q, tcnt_d;
  logic tick;
  assign tick = (tcnt_q == 18'(TICK_CYCLES - 1));
  always_comb
  begin
    tcnt_d = tick ? 18'h0_0000 : tcnt_q + 18'h0_0001;
  end

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      tcnt_q <= 18'h0_0000;
    else
      tcnt_q <= tcnt_d;
  end

  // Regulator datapath and sequencing
  ppr_s32_t set_q, set_d, fbf_q, fbf_d, acc_q, acc_d;
  ppr_s32_t out_q, out_d, outf_q, outf_d;
  logic lim_q, lim_d;
  logic [19:0] hcnt_q, hcnt_d;
  logic [15:0] lcnt_q, lcnt_d;
  ppr_s32_t sp, fbin, e, ae, kp, ti, td, p, it, dt, sum, tgt, amax;
  ppr_s32_t stp, hzv;
  logic running, dead, freeze;

  assign running = RUN || stopop;

  always_comb
  begin
    st_d = st_q;
    set_d = set_q;
    fbf_d = fbf_q;
    acc_d = acc_q;
    out_d = out_q;
    outf_d = outf_q;
    hz_d = hz_q;
    lim_d = lim_q;
    hcnt_d = hcnt_q;
    lcnt_d = lcnt_q;
    fault_d = fault_q;
    grp2_d = grp2_q;
    hzv = 0;
    // Relative values capped at full scale
    sp = clamp($signed(32'(SETTING)), 0, FULL);
    fbin = clamp($signed(32'(FEEDBACK)), 0, FULL);
    // Ramp step; lower clamp to 1 keeps at least one count per tick
    stp = (ramp == 16'h0000) ? FULL
          : clamp(RAMP_NUM / $signed(32'(ramp)), 1, FULL);
    if (tick)
    begin
      set_d = (set_q < sp) ? clamp(set_q + stp, 0, sp)
              : clamp(set_q - stp, sp, FULL);
      fbf_d = lpf(fbf_q, fbin, fbtau);
    end
    e = dir ? fbf_d - set_d : set_d - fbf_d;
    ae = (e < 0) ? -e : e;
    dead = (ae < $signed(32'(devlim)));
    unique case (swm)
      SW_INPUT: grp2_d = GAIN_SEL_IN;
      SW_AUTO: grp2_d = ae > $signed(32'(th1));
      default: grp2_d = 1'b0;
    endcase
    if (swm == SW_AUTO)
    begin
      kp = mix(kp1, kp2, ae, th1, th2);
      ti = mix(ti1, ti2, ae, th1, th2);
      td = mix(td1, td2, ae, th1, th2);
    end
    else
    begin
      kp = $signed(32'(grp2_d ? kp2 : kp1));
      ti = $signed(32'(grp2_d ? ti2 : ti1));
      td = $signed(32'(grp2_d ? td2 : td1));
    end
    ti = (ti < 1) ? 1 : ti;
    p = e * kp / KP_UNIT;
    // Derivative acts on feedback only, avoiding setting kicks
    dt = (dir ? (fbf_d - fbf_q) : (fbf_q - fbf_d)) * td / TD_DIV;
    dt = clamp(dt, -$signed(32'(dlim)), $signed(32'(dlim)));
    freeze = (isep && INT_PAUSE_IN)
             || (istop && lim_q) || dead;
    amax = FULL * TI_DIV * ti;
    // Accumulator counts deviation ticks; scale by integral time
    it = clamp(acc_q + e, -amax, amax);
    it = freeze ? clamp(acc_q, -amax, amax) : it;
    sum = p + it / (TI_DIV * ti) + dt;
    tgt = clamp(sum, -FULL, FULL);
    // Loss detection runs in every state
    if (tick)
    begin
      if (losslvl != 16'h0000 && fbin < $signed(32'(losslvl)))
      begin
        if (lcnt_q != 16'hFFFF)
          lcnt_d = lcnt_q + 16'h0001;
        if (32'(lcnt_q) >= 32'(losstime) * LOSS_MUL)
          fault_d = 1'b1;
      end
      else
        lcnt_d = 16'h0000;
    end
    if (fault_clr && fault_d == fault_q)
      fault_d = 1'b0;
    unique case (st_q)
      ST_IDLE:
      begin
        acc_d = 0;
        out_d = 0;
        outf_d = 0;
        hz_d = 0;
        lim_d = 1'b0;
        if (running)
        begin
          st_d = ST_HOLD;
          hcnt_d = 20'h0_0000;
        end
      end
      ST_HOLD:
      begin
        out_d = $signed(32'(initv));
        outf_d = out_d;
        hz_d = clamp(out_d * $signed(32'(maxf)) / FULL,
                     -$signed(32'(cutoff)), 32'sh7FFF_FFFF);
        if (!running)
          st_d = ST_IDLE;
        else if (tick)
        begin
          hcnt_d = hcnt_q + 20'h0_0001;
          if (32'(hcnt_q) >= 32'(hold) * TI_DIV)
          begin
            st_d = ST_RUN;
            acc_d = 0;
          end
        end
      end
      ST_RUN:
      begin
        if (!running)
          st_d = ST_IDLE;
        else if (tick)
        begin
          acc_d = it;
          lim_d = (sum != tgt);
          if (dead)
            tgt = out_q;
          out_d = out_q + clamp(tgt - out_q, -$signed(32'(stepr)),
                                $signed(32'(stepf)));
          outf_d = lpf(outf_q, out_d, otau);
          hzv = outf_d * $signed(32'(maxf)) / FULL;
          hz_d = (hzv < -$signed(32'(cutoff))) ?
                 -$signed(32'(cutoff)) : hzv;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st_q <= ST_IDLE;
      set_q <= 0;
      fbf_q <= 0;
      acc_q <= 0;
      out_q <= 0;
      outf_q <= 0;
      hz_q <= 0;
      lim_q <= 1'b0;
      hcnt_q <= 20'h0_0000;
      lcnt_q <= 16'h0000;
      fault_q <= 1'b0;
      grp2_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      set_q <= set_d;
      fbf_q <= fbf_d;
      acc_q <= acc_d;
      out_q <= out_d;
      outf_q <= outf_d;
      hz_q <= hz_d;
      lim_q <= lim_d;
      hcnt_q <= hcnt_d;
      lcnt_q <= lcnt_d;
      fault_q <= fault_d;
      grp2_q <= grp2_d;
    end
  end

  assign FREQ_REF = hz_q;
  assign FEEDBACK_LOSS_FAULT = fault_q;

  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_start;
    st_q == ST_IDLE && running;
  endsequence
  sequence s_held;
    st_q == ST_HOLD [*2];
  endsequence

  start_hold_a: assert property (s_start |=> s_held or
    (st_q == ST_HOLD ##1 st_q != ST_HOLD))
    else $error("start did not enter hold");
  hold_value_a: assert property (st_q == ST_HOLD ##1 st_q == ST_HOLD
    |-> out_q == $signed(32'(initv)))
    else $error("hold output not initial value");
  rev_cutoff_a: assert property (
    FREQ_REF >= -$signed(32'(cutoff)) || $changed(cutoff))
    else $error("reverse cut-off exceeded");
  slew_limit_a: assert property (
    st_q == ST_RUN && tick && running |=>
    (out_q - $past(out_q)) <= $signed(32'($past(stepf)))
    && ($past(out_q) - out_q) <= $signed(32'($past(stepr))))
    else $error("output step too large");
  dead_band_a: assert property (
    st_q == ST_RUN && tick && running && dead |=> $stable(out_q))
    else $error("output moved inside dead band");
  int_pause_a: assert property (
    st_q == ST_RUN && tick && running && isep && INT_PAUSE_IN
    && acc_q <= amax && acc_q >= -amax |=> $stable(acc_q))
    else $error("integrator moved while paused");
  stop_halt_a: assert property (
    st_q != ST_IDLE && !running |=> st_q == ST_IDLE ##1 hz_q == 0)
    else $error("regulation did not halt");
  loss_off_a: assert property (
    losslvl == 16'h0000 && !fault_q ##1 losslvl == 16'h0000
    |-> !fault_q)
    else $error("fault with detection off");
  ramp_zero_a: assert property (
    tick && ramp == 16'h0000 |=> set_q == $past(sp))
    else $error("setting not applied at once");
  deriv_clamp_a: assert property (
    dt <= $signed(32'(dlim)) && dt >= -$signed(32'(dlim)))
    else $error("derivative beyond limit");
  tick_space_a: assert property (tick |=> !tick [*8])
    else $error("tick too frequent");
endmodule : ppr_regulator
`default_nettype wire

// ==== sim/ppr_process_model.sv ====
// Purpose: process side model feeding the regulator
// Assumes: bench asks for feedback levels in 0.01 % units
// Notes: transmitter saturates at full scale, terminals are levels
`timescale 1ns/1ps
`default_nettype none
module ppr_process_model
  import ppr_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic [15:0] level,
  input wire logic sel,
  input wire logic pause,
  output logic [15:0] FEEDBACK,
  output logic GAIN_SEL_IN,
  output logic INT_PAUSE_IN
);
  // Outputs settle one edge after a request, never on the sampling edge
  always_ff @(posedge REF_CLK)
  begin
    FEEDBACK <= (level > FULL) ? 16'(FULL) : level;
    GAIN_SEL_IN <= sel;
    INT_PAUSE_IN <= pause;
  end
endmodule : ppr_process_model
`default_nettype wire

// ==== sim/tb_process_pid_regulator.sv ====
// Purpose: self-checking bench for the process PID regulator
// Assumes: tick shortened to 20 cycles, step 1 % of 50.00 Hz max
// Notes: regulator outputs are sampled on the falling edge to avoid races, APB read data on the rising edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, a, e); end end
module tb_process_pid_regulator
  import ppr_pkg::*;
;
  localparam int TK = 20;
  localparam int STEP_HZ = 100 * 5000 / 10000;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] setting, fb_level, feedback;
  logic run, sel, pause, gain_sel, int_pause, fault;
  logic signed [31:0] freq;
  int errors, comparisons;
  ppr_regulator #(.TICK_CYCLES(TK)) i_ppr_regulator (.REF_CLK(clk),
    .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SETTING(setting), .FEEDBACK(feedback), .RUN(run),
    .GAIN_SEL_IN(gain_sel), .INT_PAUSE_IN(int_pause), .FREQ_REF(freq),
    .FEEDBACK_LOSS_FAULT(fault));
  ppr_process_model i_ppr_process_model (.REF_CLK(clk), .level(fb_level),
    .sel(sel), .pause(pause), .FEEDBACK(feedback), .GAIN_SEL_IN(gain_sel),
    .INT_PAUSE_IN(int_pause));
  // Free running 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic summarize;
    $display("totals: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  // One APB transfer; waits for pready rather than assuming zero waits
  task automatic apb(input logic w, input logic [3:0] r, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, r, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait that never sees pready
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK(pready, 1'b1)
  endtask : apb
  task automatic ticks(input int n);
    repeat (n * TK) @(negedge clk);
  endtask : ticks
  // Every output change is step limited and never beyond reverse cut-off
  task automatic watch(input int n);
    logic signed [31:0] p, d;
    p = freq;
    repeat (n * TK)
    begin
      @(negedge clk);
      d = freq - p;
      `CHK(d <= STEP_HZ && d >= -STEP_HZ, 1'b1)
      `CHK(freq >= -32'sd200, 1'b1)
      p = freq;
    end
  endtask : watch
  task automatic t_regs;
    logic [3:0] idx [7] = '{R_GAIN1, R_GAIN2, R_THR, R_LIMIT, R_HOLD,
      R_STEP, R_MAXF};
    logic [31:0] exp [7] = '{32'h00C8_00C8, 32'h00C8_00C8, 32'h1F40_07D0,
      32'h000A_0000, 32'h00C8_0000, 32'h0064_0064, 32'h0000_1388};
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, idx[i], 32'h0);
      `CHK(rd, exp[i])
    end
    apb(1'b1, R_OUT, 32'h0000_1234);
    apb(1'b0, R_OUT, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 4'hE, 32'h0);
    `CHK({er, rd}, 33'h1_0000_0000)
    $display("test regs done");
  endtask : t_regs
  task automatic t_start;
    apb(1'b1, R_RAMP, 32'h1388_0000);
    apb(1'b1, R_HOLD, 32'h00C8_0001);
    run <= 1'b1;
    repeat (3) @(negedge clk);
    `CHK(freq, 32'sd2500)
    apb(1'b0, R_STAT, 32'h0);
    `CHK(rd[2:1], 2'b01)
    $display("test start done");
  endtask : t_start
  // Full dead band: output must not move after the hold ends
  task automatic t_band;
    apb(1'b1, R_LIMIT, 32'h000A_2710);
    ticks(20);
    `CHK(freq, 32'sd2500)
    apb(1'b1, R_LIMIT, 32'h000A_0000);
    $display("test band done");
  endtask : t_band
  task automatic t_dir;
    logic signed [31:0] p;
    // Full deviation at gain 100.0 asks for full output: slew bound
    setting <= 16'd10000;
    fb_level <= 16'd0;
    apb(1'b1, R_GAIN1, 32'h00C8_03E8);
    @(negedge clk);
    p = freq;
    watch(30);
    `CHK(freq, p + 32'sd1500)
    apb(1'b1, R_CTRL, 32'h1);
    watch(120);
    `CHK(freq, -32'sd200)
    $display("test direction done");
  endtask : t_dir
  task automatic t_gain;
    logic [3:0] c [5] = '{4'h3, 4'h3, 4'h1, 4'h5, 4'h5};
    logic [4:0] s = 5'b00101;
    logic [4:0] f = 5'b10000;
    logic [4:0] x = 5'b01001;
    @(posedge clk);
    setting <= 16'd8000;
    for (int i = 0; i < 5; i++)
    begin
      sel <= s[i];
      fb_level <= f[i] ? 16'd8000 : 16'd2000;
      apb(1'b1, R_CTRL, {28'h0, c[i]});
      ticks(2);
      apb(1'b0, R_STAT, 32'h0);
      `CHK(rd[3], x[i])
    end
    $display("test gain done");
  endtask : t_gain
  task automatic t_stop;
    run <= 1'b0;
    ticks(2);
    `CHK(freq, 32'sd0)
    $display("test stop done");
  endtask : t_stop
  // Integral only loop; pause with separation on holds it at zero
  task automatic t_pause;
    @(posedge clk);
    pause <= 1'b1;
    fb_level <= 16'd2000;
    apb(1'b1, R_GAIN1, 32'h00C8_0000);
    apb(1'b1, R_RAMP, 32'h0);
    apb(1'b1, R_CTRL, 32'h10);
    run <= 1'b1;
    ticks(20);
    `CHK(freq, 32'sd0)
    @(posedge clk);
    pause <= 1'b0;
    ticks(10);
    `CHK(freq > 32'sd0, 1'b1)
    $display("test pause done");
  endtask : t_pause
  task automatic t_loss;
    @(posedge clk);
    fb_level <= 16'd0;
    apb(1'b1, R_LOSS, 32'h0001_03E8);
    ticks(40);
    `CHK(fault, 1'b0)
    ticks(15);
    `CHK(fault, 1'b1)
    apb(1'b1, R_LOSS, 32'h0);
    fb_level <= 16'd5000;
    apb(1'b1, R_STAT, 32'h1);
    ticks(1);
    `CHK(fault, 1'b0)
    $display("test loss done");
  endtask : t_loss
  // Main sequence, reset held for 16 cycles
  initial
  begin
    {rst_n, psel, penable, pwrite, run, sel, pause} = 7'h0;
    paddr = '0;
    pwdata = 32'h0;
    setting = 16'd8000;
    fb_level = 16'd2000;
    errors = 0;
    comparisons = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_start;
    t_band;
    t_dir;
    t_gain;
    t_stop;
    t_pause;
    t_loss;
    summarize;
  end
  // Watchdog well beyond the roughly 44 us the tests need
  initial
  begin
    #500000;
    errors++;
    summarize;
  end
endmodule : tb_process_pid_regulator
`default_nettype wire
